// ==== core/codec_touch_control_regs.v ====
// Control/status register bank for audio codec, telecom codec and touch plates
// Assumes a word-wide register port decoded from the serial frame: address, write
// strobe, write data; read data is registered. Clip inputs are synchronous.
// Operation
// - Zero-to-one write on bit 14/15 clears telecom/audio clip interrupt
// - Bits 14/15 of interrupt status read pending clip interrupts, reset zero
// - Telecom divisor in bits 0-6, resets to 16; host writes 16..127
// - Telecom control A bit 7 puts telecom codec in loopback
// - Telecom control B bit 3 enables voice-band input filter
// - Telecom control B bit 4 reads sticky telecom clip flag
// - Zero-to-one write on telecom B bit 4 clears telecom clip flag
// - Telecom control B bit 6 enables 6 dB input cut
// - Telecom control B bit 11 enables sidetone suppression
// - Telecom control B bit 13 mutes telecom output
// - Telecom B bits 14/15 enable telecom input/output paths
// - Audio divisor in bits 0-6, resets to 6; host writes 6..127
// - Audio A bits 7-11 select input gain, reset zero
// - Audio B bits 0-4 select output attenuation, reset zero
// - Audio B bit 6 reads sticky audio clip flag
// - Zero-to-one write on audio B bit 6 clears audio clip flag
// - Audio B bit 8 puts audio codec in loopback
// - Audio B bit 13 mutes audio output
// - Audio B bits 14/15 enable audio input/output paths
// - Touch bits 0-3 power negative-X, positive-X, negative-Y, positive-Y plates
// - Touch bit 4 grounds the negative-X plate
// - Rise enable bits 14/15 let clip rising edge raise interrupt
// - Fall enable bits 14/15 let clip falling edge raise interrupt
`timescale 1ns/1ns
`include "codec_regs_defines.vh"
module codec_touch_control_regs
(
    input  wire        sys_clk,
    input  wire        arst_n,
    input  wire        clkEn,
    input  wire [3:0]  regAddr,
    input  wire        regWrite,
    input  wire [15:0] regWdata,
    input  wire        regRead,
    output reg  [15:0] regRdata,
    input  wire        telClipDetect,
    input  wire        audClipDetect,
    output wire        clipIrq,
    output wire [6:0]  tel_rate_divisor,
    output wire        tel_loopback,
    output wire        tel_voiceband_filter_on,
    output wire        tel_input_6db_cut,
    output wire        sidetone_cancel_on,
    output wire        tel_output_silence,
    output wire        tel_input_path_on,
    output wire        tel_output_path_on,
    output wire [6:0]  aud_rate_divisor,
    output wire [4:0]  aud_input_gain,
    output wire [4:0]  aud_output_attenuation,
    output wire        aud_loopback,
    output wire        aud_output_silence,
    output wire        aud_input_path_on,
    output wire        aud_output_path_on,
    output wire        neg_x_plate_power,
    output wire        pos_x_plate_power,
    output wire        neg_y_plate_power,
    output wire        pos_y_plate_power,
    output wire        neg_x_plate_ground
);
    reg  [15:0] telA_r;
    reg  [15:0] telB_r;
    reg  [15:0] audA_r;
    reg  [15:0] audB_r;
    reg  [15:0] touch_r;
    reg  [15:0] riseEn_r;
    reg  [15:0] fallEn_r;
    reg         telClipLast_r;
    reg         audClipLast_r;
    reg  [15:0] rdata_nxt;
    wire        tel_clip_flag;
    wire        aud_clip_flag;
    wire        tel_clip_irq_pending;
    wire        aud_clip_irq_pending;
    wire [15:0] irqRise;
    wire [15:0] telBRise;
    wire [15:0] audBRise;
    wire        telClipEdge;
    wire        audClipEdge;

    function wrSel;
        input [3:0] a;
        begin
            wrSel = regWrite && (regAddr == a);
        end
    endfunction

    function [15:0] merge;
        input [15:0] d;
        input [15:0] m;
        begin
            merge = d & m;
        end
    endfunction

    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            telA_r   <= {9'h000, `RST_TEL_RATE_DIVISOR};
            telB_r   <= 16'h0000;
            audA_r   <= {9'h000, `RST_AUD_RATE_DIVISOR};
            audB_r   <= 16'h0000;
            touch_r  <= 16'h0000;
            riseEn_r <= 16'h0000;
            fallEn_r <= 16'h0000;
        end
        else if (clkEn)
        begin
            if (wrSel(`ADDR_TEL_CTRL_A))
                telA_r <= merge(regWdata, `MASK_TEL_A);
            if (wrSel(`ADDR_TEL_CTRL_B))
                telB_r <= merge(regWdata, `MASK_TEL_B);
            if (wrSel(`ADDR_AUD_CTRL_A))
                audA_r <= merge(regWdata, `MASK_AUD_A);
            if (wrSel(`ADDR_AUD_CTRL_B))
                audB_r <= merge(regWdata, `MASK_AUD_B);
            if (wrSel(`ADDR_TOUCH_CTRL))
                touch_r <= merge(regWdata, `MASK_TOUCH);
            if (wrSel(`ADDR_RISE_EN))
                riseEn_r <= merge(regWdata, `MASK_IRQ_EN);
            if (wrSel(`ADDR_FALL_EN))
                fallEn_r <= merge(regWdata, `MASK_IRQ_EN);
        end
    end

    // Previous clip levels for edge detection
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            telClipLast_r <= 1'b0;
            audClipLast_r <= 1'b0;
        end
        else if (clkEn)
        begin
            telClipLast_r <= telClipDetect;
            audClipLast_r <= audClipDetect;
        end
    end

    // Write-transition clear detectors
    rise_detect u_irqClr
    (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .strobe  (clkEn && wrSel(`ADDR_IRQ_STAT)),
        .dataIn  (regWdata),
        .rise    (irqRise)
    );

    rise_detect u_telBClr
    (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .strobe  (clkEn && wrSel(`ADDR_TEL_CTRL_B)),
        .dataIn  (regWdata),
        .rise    (telBRise)
    );

    rise_detect u_audBClr
    (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .strobe  (clkEn && wrSel(`ADDR_AUD_CTRL_B)),
        .dataIn  (regWdata),
        .rise    (audBRise)
    );

    // Sticky clip-detect flags
    sticky_flag u_telClip
    (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .setIn   (telClipDetect),
        .clrIn   (telBRise[`BIT_TEL_CLIP]),
        .flag    (tel_clip_flag)
    );

    sticky_flag u_audClip
    (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .setIn   (audClipDetect),
        .clrIn   (audBRise[`BIT_AUD_CLIP]),
        .flag    (aud_clip_flag)
    );

    // Clip interrupts on enabled rising or falling edges
    assign telClipEdge = (riseEn_r[`BIT_TEL_CLIP_IRQ] && telClipDetect && !telClipLast_r)
                      || (fallEn_r[`BIT_TEL_CLIP_IRQ] && !telClipDetect && telClipLast_r);
    assign audClipEdge = (riseEn_r[`BIT_AUD_CLIP_IRQ] && audClipDetect && !audClipLast_r)
                      || (fallEn_r[`BIT_AUD_CLIP_IRQ] && !audClipDetect && audClipLast_r);

    sticky_flag u_telIrq
    (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .setIn   (telClipEdge),
        .clrIn   (irqRise[`BIT_TEL_CLIP_IRQ]),
        .flag    (tel_clip_irq_pending)
    );

    sticky_flag u_audIrq
    (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .setIn   (audClipEdge),
        .clrIn   (irqRise[`BIT_AUD_CLIP_IRQ]),
        .flag    (aud_clip_irq_pending)
    );

    assign clipIrq = tel_clip_irq_pending | aud_clip_irq_pending;

    // Read multiplexer; unmapped addresses read zero
    always @*
    begin
        rdata_nxt = 16'h0000;
        case (regAddr)
            `ADDR_RISE_EN:    rdata_nxt = riseEn_r;
            `ADDR_FALL_EN:    rdata_nxt = fallEn_r;
            `ADDR_IRQ_STAT:
            begin
                rdata_nxt[`BIT_TEL_CLIP_IRQ] = tel_clip_irq_pending;
                rdata_nxt[`BIT_AUD_CLIP_IRQ] = aud_clip_irq_pending;
            end
            `ADDR_TEL_CTRL_A: rdata_nxt = telA_r;
            `ADDR_TEL_CTRL_B:
            begin
                rdata_nxt = telB_r;
                rdata_nxt[`BIT_TEL_CLIP] = tel_clip_flag;
            end
            `ADDR_AUD_CTRL_A: rdata_nxt = audA_r;
            `ADDR_AUD_CTRL_B:
            begin
                rdata_nxt = audB_r;
                rdata_nxt[`BIT_AUD_CLIP] = aud_clip_flag;
            end
            `ADDR_TOUCH_CTRL: rdata_nxt = touch_r;
            default:          rdata_nxt = 16'h0000;
        endcase
    end

    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            regRdata <= 16'h0000;
        else if (clkEn && regRead)
            regRdata <= rdata_nxt;
    end

    assign tel_rate_divisor        = telA_r[6:0];
    assign tel_loopback            = telA_r[`BIT_TEL_LOOPBACK];
    assign tel_voiceband_filter_on = telB_r[`BIT_TEL_FILTER];
    assign tel_input_6db_cut       = telB_r[`BIT_TEL_CUT];
    assign sidetone_cancel_on      = telB_r[`BIT_TEL_SIDETONE];
    assign tel_output_silence      = telB_r[`BIT_TEL_SILENCE];
    assign tel_input_path_on       = telB_r[`BIT_TEL_IN_ON];
    assign tel_output_path_on      = telB_r[`BIT_TEL_OUT_ON];
    assign aud_rate_divisor        = audA_r[6:0];
    assign aud_input_gain          = audA_r[11:7];
    assign aud_output_attenuation  = audB_r[4:0];
    assign aud_loopback            = audB_r[`BIT_AUD_LOOPBACK];
    assign aud_output_silence      = audB_r[`BIT_AUD_SILENCE];
    assign aud_input_path_on       = audB_r[`BIT_AUD_IN_ON];
    assign aud_output_path_on      = audB_r[`BIT_AUD_OUT_ON];
    assign neg_x_plate_power       = touch_r[0];
    assign pos_x_plate_power       = touch_r[1];
    assign neg_y_plate_power       = touch_r[2];
    assign pos_y_plate_power       = touch_r[3];
    assign neg_x_plate_ground      = touch_r[`BIT_NEG_X_GND];
endmodule // codec_touch_control_regs

// ==== core/codec_regs_defines.vh ====
// Register offsets, field positions and reset values of the codec/touch control bank
// Included by the register bank module only, not by rise_detect or sticky_flag
`ifndef CODEC_REGS_DEFINES_VH
`define CODEC_REGS_DEFINES_VH

`define ADDR_RISE_EN      4'h2
`define ADDR_FALL_EN      4'h3
`define ADDR_IRQ_STAT     4'h4
`define ADDR_TEL_CTRL_A   4'h5
`define ADDR_TEL_CTRL_B   4'h6
`define ADDR_AUD_CTRL_A   4'h7
`define ADDR_AUD_CTRL_B   4'h8
`define ADDR_TOUCH_CTRL   4'h9

`define BIT_TEL_CLIP_IRQ  14
`define BIT_AUD_CLIP_IRQ  15

`define BIT_TEL_LOOPBACK      7
`define BIT_TEL_FILTER    3
`define BIT_TEL_CLIP      4
`define BIT_TEL_CUT       6
`define BIT_TEL_SIDETONE  11
`define BIT_TEL_SILENCE   13
`define BIT_TEL_IN_ON     14
`define BIT_TEL_OUT_ON    15

`define BIT_AUD_CLIP      6
`define BIT_AUD_LOOPBACK      8
`define BIT_AUD_SILENCE   13
`define BIT_AUD_IN_ON     14
`define BIT_AUD_OUT_ON    15

`define BIT_NEG_X_GND     4

`define RST_TEL_RATE_DIVISOR       7'h10
`define RST_AUD_RATE_DIVISOR       7'h06

// Writable masks of each control register
`define MASK_TEL_A        16'h00ff
`define MASK_TEL_B        16'he848
`define MASK_AUD_A        16'h0fff
`define MASK_AUD_B        16'he11f
`define MASK_TOUCH        16'h001f
`define MASK_IRQ_EN       16'hc000

`endif

// ==== core/rise_detect.v ====
// Zero-to-one detector on a bus, used for write-transition clears
// Assumes the written bus is valid whenever strobe is high
`timescale 1ns/1ns
module rise_detect
(
    input  wire        sys_clk,
    input  wire        arst_n,
    input  wire        clkEn,
    input  wire        strobe,
    input  wire [15:0] dataIn,
    output wire [15:0] rise
);
    reg [15:0] last_r;

    // Clears fire only on a write whose bit was zero in the previous write
    assign rise = strobe ? (dataIn & ~last_r) : 16'h0000;

    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            last_r <= 16'h0000;
        else if (clkEn && strobe)
            last_r <= dataIn;
    end
endmodule // rise_detect

// ==== core/sticky_flag.v ====
// Sticky flag: set by an event, cleared by a pulse; set wins over clear
// Assumes set and clear are one-cycle synchronous pulses
`timescale 1ns/1ns
module sticky_flag
(
    input  wire sys_clk,
    input  wire arst_n,
    input  wire clkEn,
    input  wire setIn,
    input  wire clrIn,
    output reg  flag
);
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            flag <= 1'b0;
        else if (clkEn)
            flag <= setIn | (flag & ~clrIn);
    end
endmodule // sticky_flag

// ==== testbench/codec_regs_chk.sv ====
// Port-level checker of the codec/touch control bank
// Assumes one clock domain and a controller that keeps divisors in range
`timescale 1ns/1ns
module codec_regs_chk
(
    input wire        sys_clk,
    input wire        arst_n,
    input wire        clkEn,
    input wire [3:0]  regAddr,
    input wire        regWrite,
    input wire [15:0] regWdata,
    input wire        regRead,
    input wire [15:0] regRdata,
    input wire        telClipDetect,
    input wire        audClipDetect,
    input wire [6:0]  tel_rate_divisor,
    input wire        tel_loopback,
    input wire [6:0]  aud_rate_divisor,
    input wire [4:0]  aud_input_gain,
    input wire        neg_x_plate_ground
);
    wire wrEn = clkEn && regWrite;
    wire rdEn = clkEn && regRead;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    chk_tel_rate_divisor_range: assert property (tel_rate_divisor >= 7'h10)
        else $error("telecom divisor below range");
    chk_aud_rate_divisor_range: assert property (aud_rate_divisor >= 7'h06)
        else $error("audio divisor below range");
    chk_tel_a_write: assert property (wrEn && regAddr == 4'h5 |=>
        tel_loopback == $past(regWdata[7]) && tel_rate_divisor == $past(regWdata[6:0]))
        else $error("telecom control A not applied");
    chk_tel_a_hold: assert property (!(wrEn && regAddr == 4'h5) |=> $stable(tel_loopback))
        else $error("telecom loopback changed without write");
    chk_aud_a_write: assert property (wrEn && regAddr == 4'h7 |=>
        aud_input_gain == $past(regWdata[11:7]) && aud_rate_divisor == $past(regWdata[6:0]))
        else $error("audio control A not applied");
    chk_touch_ground: assert property (wrEn && regAddr == 4'h9 |=>
        neg_x_plate_ground == $past(regWdata[4]))
        else $error("plate ground not applied");
    chk_unmapped_read: assert property (rdEn && (regAddr < 4'h2 || regAddr > 4'h9) |=>
        regRdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_tel_clip_sticky: assert property (clkEn && telClipDetect ##1 rdEn && regAddr == 4'h6 |=>
        regRdata[4])
        else $error("telecom clip flag not set");
    chk_aud_clip_sticky: assert property (clkEn && audClipDetect ##1 rdEn && regAddr == 4'h8 |=>
        regRdata[6])
        else $error("audio clip flag not set");
endmodule // codec_regs_chk

bind codec_touch_control_regs codec_regs_chk chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRead(regRead), .regRdata(regRdata), .telClipDetect(telClipDetect),
    .audClipDetect(audClipDetect), .tel_rate_divisor(tel_rate_divisor),
    .tel_loopback(tel_loopback), .aud_rate_divisor(aud_rate_divisor),
    .aud_input_gain(aud_input_gain), .neg_x_plate_ground(neg_x_plate_ground));

// ==== testbench/sys_ctrl_model.sv ====
// Controller model: word reads and writes on the bank's register port
// Assumes requests change 1 ns after the rising edge
`timescale 1ns/1ns
module sys_ctrl_model
(
    input  wire        sys_clk,
    input  wire [15:0] regRdata,
    output reg  [3:0]  regAddr,
    output reg         regWrite,
    output reg  [15:0] regWdata,
    output reg         regRead
);
    initial
    begin
        regAddr = 4'h0;
        regWrite = 1'b0;
        regWdata = 16'h0000;
        regRead = 1'b0;
    end
    task wr(input [3:0] a, input [15:0] d);
    begin
        if ((a == 4'h5 && d[6:0] < 7'h10) || (a == 4'h7 && d[6:0] < 7'h06))
            d[6:0] = 7'h7f;
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge sys_clk);
        #1;
        regWrite = 1'b0;
        // Idle data lines show the inverse, never the last word
        regWdata = ~d;
    end
    endtask
    task rd(input [3:0] a, output [15:0] q);
    begin
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge sys_clk);
        #1;
        q = regRdata;
        regRead = 1'b0;
    end
    endtask
endmodule // sys_ctrl_model

// ==== testbench/tb.sv ====
// Self-checking bench of the codec/touch control bank
// Assumes the controller model drives the register port; clip inputs driven here
`timescale 1ns/1ns
module tb;
    reg         sys_clk;
    reg         arst_n;
    reg         clkEn;
    reg         telClipDetect;
    reg         audClipDetect;
    wire [3:0]  regAddr;
    wire        regWrite, regRead, clipIrq;
    wire [15:0] regWdata, regRdata;
    wire [6:0]  tel_rate_divisor, aud_rate_divisor;
    wire [4:0]  aud_input_gain, aud_output_attenuation;
    wire        tel_loopback, tel_voiceband_filter_on, tel_input_6db_cut, sidetone_cancel_on;
    wire        tel_output_silence, tel_input_path_on, tel_output_path_on, aud_loopback;
    wire        aud_output_silence, aud_input_path_on, aud_output_path_on, neg_x_plate_ground;
    wire        neg_x_plate_power, pos_x_plate_power, neg_y_plate_power, pos_y_plate_power;
    integer     errTotal, nCompared, cycles;
    reg  [15:0] q;
    wire [5:0]  telB = {tel_output_path_on, tel_input_path_on, tel_output_silence,
                        sidetone_cancel_on, tel_input_6db_cut, tel_voiceband_filter_on};
    wire [8:0]  audB = {aud_output_path_on, aud_input_path_on, aud_output_silence,
                        aud_loopback, aud_output_attenuation};
    wire [4:0]  touch = {neg_x_plate_ground, pos_y_plate_power, neg_y_plate_power,
                         pos_x_plate_power, neg_x_plate_power};
    sys_ctrl_model ctrl (.sys_clk(sys_clk), .regRdata(regRdata), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead));
    codec_touch_control_regs dut (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn),
        .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
        .regRdata(regRdata), .telClipDetect(telClipDetect), .audClipDetect(audClipDetect),
        .clipIrq(clipIrq), .tel_rate_divisor(tel_rate_divisor), .tel_loopback(tel_loopback),
        .tel_voiceband_filter_on(tel_voiceband_filter_on), .tel_input_6db_cut(tel_input_6db_cut),
        .sidetone_cancel_on(sidetone_cancel_on), .tel_output_silence(tel_output_silence),
        .tel_input_path_on(tel_input_path_on), .tel_output_path_on(tel_output_path_on),
        .aud_rate_divisor(aud_rate_divisor), .aud_input_gain(aud_input_gain),
        .aud_output_attenuation(aud_output_attenuation), .aud_loopback(aud_loopback),
        .aud_output_silence(aud_output_silence), .aud_input_path_on(aud_input_path_on),
        .aud_output_path_on(aud_output_path_on), .neg_x_plate_power(neg_x_plate_power),
        .pos_x_plate_power(pos_x_plate_power), .neg_y_plate_power(neg_y_plate_power),
        .pos_y_plate_power(pos_y_plate_power), .neg_x_plate_ground(neg_x_plate_ground));
    task check(input string what, input [15:0] seen, input [15:0] exp);
    begin
        nCompared = nCompared + 1;
        if (seen !== exp)
        begin
            errTotal = errTotal + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task rchk(input [3:0] a, input [15:0] exp);
    begin
        ctrl.rd(a, q);
        check("regRdata", q, exp);
    end
    endtask
    task clip(input tel, input lvl);
    begin
        @(posedge sys_clk);
        #1;
        if (tel)
            telClipDetect = lvl;
        else
            audClipDetect = lvl;
    end
    endtask
    task conclude;
    begin
        $display("compared %0d, errors %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task t_reset;
    begin
        check("clipIrq", clipIrq, 16'h0000);
        check("telDiv", tel_rate_divisor, 16'h0010);
        check("audDiv", aud_rate_divisor, 16'h0006);
        check("telOut", {tel_loopback, telB}, 16'h0000);
        check("audOut", {aud_input_gain, audB}, 16'h0000);
        check("touch", touch, 16'h0000);
        rchk(4'h4, 16'h0000);
        rchk(4'h6, 16'h0000);
        rchk(4'h8, 16'h0000);
    end
    endtask
    task t_ctrl;
    begin
        ctrl.wr(4'h5, 16'hffff);
        rchk(4'h5, 16'h00ff);
        check("telDiv", {tel_loopback, tel_rate_divisor}, 16'h00ff);
        ctrl.wr(4'h6, 16'hffff);
        rchk(4'h6, 16'he848);
        check("telB", telB, 16'h003f);
        ctrl.wr(4'h6, 16'h4048);
        check("telB", telB, 16'h0013);
        ctrl.wr(4'h7, 16'h0786);
        rchk(4'h7, 16'h0786);
        check("audA", {aud_input_gain, aud_rate_divisor}, 16'h0786);
        ctrl.wr(4'h8, 16'hffff);
        rchk(4'h8, 16'he11f);
        check("audB", audB, 16'h01ff);
        ctrl.wr(4'h8, 16'h0101);
        check("audB", audB, 16'h0021);
        ctrl.wr(4'h9, 16'hffff);
        rchk(4'h9, 16'h001f);
        ctrl.wr(4'h9, 16'h0005);
        check("touch", touch, 16'h0005);
        ctrl.wr(4'hf, 16'hffff);
        rchk(4'hf, 16'h0000);
        rchk(4'h0, 16'h0000);
    end
    endtask
    task t_clip;
    begin
        ctrl.wr(4'h2, 16'hc000);
        clip(1'b1, 1'b1);
        rchk(4'h6, 16'h4058);
        clip(1'b1, 1'b0);
        check("clipIrq", clipIrq, 16'h0001);
        rchk(4'h4, 16'h4000);
        ctrl.wr(4'h6, 16'h4058);
        rchk(4'h6, 16'h4048);
        ctrl.wr(4'h4, 16'h4000);
        rchk(4'h4, 16'h0000);
        check("clipIrq", clipIrq, 16'h0000);
        clip(1'b1, 1'b1);
        clip(1'b1, 1'b0);
        ctrl.wr(4'h6, 16'h4058);
        rchk(4'h6, 16'h4058);
        ctrl.wr(4'h4, 16'h4000);
        rchk(4'h4, 16'h4000);
        ctrl.wr(4'h2, 16'h0000);
        ctrl.wr(4'h3, 16'h8000);
        clip(1'b0, 1'b1);
        rchk(4'h8, 16'h0141);
        rchk(4'h4, 16'h4000);
        clip(1'b0, 1'b0);
        rchk(4'h4, 16'hc000);
        ctrl.wr(4'h8, 16'h0141);
        rchk(4'h8, 16'h0101);
        ctrl.wr(4'h4, 16'h0000);
        ctrl.wr(4'h4, 16'hc000);
        rchk(4'h4, 16'h0000);
        ctrl.wr(4'h2, 16'h8000);
        ctrl.wr(4'h3, 16'h4000);
        clip(1'b0, 1'b1);
        clip(1'b1, 1'b1);
        rchk(4'h4, 16'h8000);
        clip(1'b1, 1'b0);
        rchk(4'h4, 16'hc000);
        clip(1'b0, 1'b0);
    end
    endtask
    // Clock enable low must ignore writes and hold the read word
    task t_freeze;
    begin
        clkEn = 1'b0;
        ctrl.wr(4'h5, 16'h0020);
        check("telA", {tel_loopback, tel_rate_divisor}, 16'h00ff);
        rchk(4'h5, 16'hc000);
        clkEn = 1'b1;
        rchk(4'h5, 16'h00ff);
    end
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            errTotal = errTotal + 1;
            conclude;
        end
    end
    initial
    begin
        errTotal = 0;
        nCompared = 0;
        cycles = 0;
        arst_n = 1'b0;
        clkEn = 1'b1;
        telClipDetect = 1'b0;
        audClipDetect = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        t_reset;
        t_ctrl;
        t_clip;
        t_freeze;
        // Mid-run reset must clear sticky flags and pending interrupts
        @(posedge sys_clk);
        #1;
        arst_n = 1'b0;
        @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        t_reset;
        conclude;
    end
endmodule // tb
